/* File: hw/pso_sequencer.sv */
// on request, output-good and standby role sequencing
`timescale 1ns/1ns
module pso_sequencer #(
  parameter int unsigned ON_DLY_CYC = pso_pkg::ON_DLY_MS * pso_pkg::CYC_PER_MS,
  parameter int unsigned PWOK_DLY_CYC = pso_pkg::PWOK_DLY_MS * pso_pkg::CYC_PER_MS,
  parameter int unsigned PARK1_CYC = pso_pkg::PARK_DLY1_MS * pso_pkg::CYC_PER_MS,
  parameter int unsigned PARK2_CYC = pso_pkg::PARK_DLY2_MS * pso_pkg::CYC_PER_MS,
  parameter int unsigned PARK3_CYC = pso_pkg::PARK_DLY3_MS * pso_pkg::CYC_PER_MS,
  parameter int unsigned BLINK_CYC = pso_pkg::BLINK_MS * pso_pkg::CYC_PER_MS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic main_on_request_pin_n,
  input wire logic outputs_in_reg,
  input wire logic current_limit,
  input wire logic input_power_lost,
  input wire logic fault,
  input wire logic warning,
  input wire logic redundancy_wake_n,
  input wire logic wake_line_in,
  output logic wake_line_oe,
  input wire logic redundancy_ok_n_in,
  output logic redundancy_ok_n_oe,
  input wire logic [7:0] load_share_level,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic [7:0] cmd_wdata,
  output logic cmd_ack,
  output logic cmd_nak,
  output logic [7:0] cmd_rdata,
  output logic main_rail_en,
  output logic power_good,
  output logic fan_run,
  output logic status_fault,
  output logic led_green,
  output logic led_amber,
  output logic [7:0] standby_role_select
);
  import pso_pkg::*;

  function automatic logic is_standby(input logic [7:0] r);
    is_standby = (r >= ROLE_STBY1) && (r <= ROLE_STBY4);
  endfunction

  // later-waking positions need more load before they come back
  function automatic logic [7:0] wake_thr(input logic [7:0] r);
    case (r)
      ROLE_STBY1: wake_thr = WAKE_THR1;
      ROLE_STBY2: wake_thr = WAKE_THR2;
      default: wake_thr = WAKE_THR3;
    endcase
  endfunction

  pso_state_type state;
  pso_state_type next_state;
  logic [TMR_W-1:0] park_lim;
  logic on_done;
  logic pwok_done;
  logic park_done;
  logic blink_done;
  logic blink;
  logic next_blink;
  logic park_ok;
  logic req;
  logic [7:0] next_role;
  logic next_ack;
  logic next_nak;
  logic [7:0] next_rdata;
  logic next_rail;
  logic next_pwok;
  logic next_fan;
  logic next_sfault;
  logic next_green;
  logic next_amber;
  logic next_wake_oe;
  logic next_rok_oe;

  assign req = !main_on_request_pin_n;

  always_comb begin
    case (standby_role_select)
      ROLE_STBY1: park_lim = TMR_W'(PARK1_CYC);
      ROLE_STBY2: park_lim = TMR_W'(PARK2_CYC);
      default: park_lim = TMR_W'(PARK3_CYC);
    endcase
  end

  // all park conditions held together; load below position level
  assign park_ok = req && redundancy_wake_n && is_standby(standby_role_select)
    && wake_line_in && redundancy_ok_n_in && !fault && !input_power_lost
    && (load_share_level < wake_thr(standby_role_select));

  pso_timer u_on_tmr (
    .clk(clk),
    .rst(rst),
    .run(state == ST_RAMP),
    .limit(TMR_W'(ON_DLY_CYC)),
    .done(on_done)
  );

  // delay start held off while any output is in current limit
  pso_timer u_pwok_tmr (
    .clk(clk),
    .rst(rst),
    .run(state == ST_ON && outputs_in_reg && !current_limit && !power_good),
    .limit(TMR_W'(PWOK_DLY_CYC)),
    .done(pwok_done)
  );

  pso_timer u_park_tmr (
    .clk(clk),
    .rst(rst),
    .run(state == ST_ON && power_good && park_ok),
    .limit(park_lim),
    .done(park_done)
  );

  pso_timer u_blink_tmr (
    .clk(clk),
    .rst(rst),
    .run(!blink_done),
    .limit(TMR_W'(BLINK_CYC)),
    .done(blink_done)
  );

  always_comb begin
    next_state = state;
    case (state)
      ST_OFF: begin
        if (req && !fault) begin
          next_state = ST_RAMP;
        end
      end
      ST_RAMP: begin
        if (on_done) begin
          next_state = ST_ON;
        end
      end
      ST_ON: begin
        if (park_done && park_ok) begin
          next_state = ST_PARK;
        end
      end
      ST_PARK: begin
        // any other lost condition wakes at once, no delay; loss of req or a fault goes to ST_OFF
        if (!park_ok) begin
          next_state = ST_ON;
        end
      end
      default: next_state = ST_OFF;
    endcase
    if (!req || fault) begin
      next_state = ST_OFF;
    end
  end

  always_comb begin
    next_role = standby_role_select;
    next_ack = 1'b0;
    next_nak = 1'b0;
    next_rdata = cmd_rdata;
    if (cmd_valid) begin
      if (cmd_code == ROLE_CMD) begin
        next_ack = 1'b1;
        if (cmd_write) begin
          next_role = cmd_wdata;
        end else begin
          next_rdata = standby_role_select;
        end
      end else begin
        next_nak = 1'b1;
        next_rdata = 8'h00;
      end
    end
    // fault beats a same-cycle write
    if (fault) begin
      next_role = ROLE_RESET;
    end
  end

  always_comb begin
    next_rail = (next_state == ST_ON);
    next_pwok = power_good;
    if (next_state == ST_OFF || next_state == ST_RAMP) begin
      next_pwok = 1'b0;
    end else if (input_power_lost) begin
      next_pwok = 1'b0;
    end else if (next_state == ST_PARK) begin
      next_pwok = 1'b1;
    end else if (!outputs_in_reg) begin
      next_pwok = 1'b0;
    end else if (pwok_done && !current_limit) begin
      next_pwok = 1'b1;
    end
    next_fan = (next_state != ST_OFF);
    next_sfault = fault && (state != ST_PARK);
    next_blink = blink_done ? !blink : blink;
    if (next_state == ST_PARK) begin
      next_green = blink && !warning;
      next_amber = blink && warning;
    end else begin
      next_green = (next_state == ST_ON) && !warning && !fault;
      next_amber = warning || fault;
    end
    // default role holds the shared line low so nobody parks
    next_wake_oe = (next_role == ROLE_STD) && req;
    // a parked warning must not wake its own supply
    next_rok_oe = fault || (warning && state != ST_PARK);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= ST_OFF;
      standby_role_select <= ROLE_RESET;
      cmd_ack <= 1'b0;
      cmd_nak <= 1'b0;
      cmd_rdata <= 8'h00;
      main_rail_en <= 1'b0;
      power_good <= 1'b0;
      fan_run <= 1'b0;
      status_fault <= 1'b0;
      blink <= 1'b0;
      led_green <= 1'b0;
      led_amber <= 1'b0;
      wake_line_oe <= 1'b0;
      redundancy_ok_n_oe <= 1'b0;
    end else begin
      state <= next_state;
      standby_role_select <= next_role;
      cmd_ack <= next_ack;
      cmd_nak <= next_nak;
      cmd_rdata <= next_rdata;
      main_rail_en <= next_rail;
      power_good <= next_pwok;
      fan_run <= next_fan;
      status_fault <= next_sfault;
      blink <= next_blink;
      led_green <= next_green;
      led_amber <= next_amber;
      wake_line_oe <= next_wake_oe;
      redundancy_ok_n_oe <= next_rok_oe;
    end
  end

  a_rail_release: assert property (@(posedge clk) disable iff (rst)
    main_on_request_pin_n |=> !main_rail_en)
    else $error("main rail still on after release");
  a_pwok_release: assert property (@(posedge clk) disable iff (rst)
    main_on_request_pin_n |=> !power_good)
    else $error("output-good still high after release");
  a_rail_min_delay: assert property (@(posedge clk) disable iff (rst)
    (state == ST_OFF) ##1 (state == ST_RAMP) |-> !main_rail_en [*2])
    else $error("main rail rose without delay");
  a_pwok_cause: assert property (@(posedge clk) disable iff (rst)
    $rose(power_good) && $past(state) == ST_ON |-> $past(pwok_done) && $past(outputs_in_reg))
    else $error("output-good rose without settled delay");
  a_pwok_loss: assert property (@(posedge clk) disable iff (rst)
    input_power_lost |=> !power_good)
    else $error("output-good high after input loss");
  a_climit_hold: assert property (@(posedge clk) disable iff (rst)
    current_limit && !power_good |=> !power_good)
    else $error("output-good rose during current limit");
  a_role_fault: assert property (@(posedge clk) disable iff (rst)
    fault |=> standby_role_select == ROLE_STD)
    else $error("role not reset on fault");
  a_park_role: assert property (@(posedge clk) disable iff (rst)
    state == ST_PARK |-> $past(is_standby(standby_role_select) && req && redundancy_wake_n))
    else $error("parked with wrong role or no request");
  a_park_hold: assert property (@(posedge clk) disable iff (rst)
    state == ST_PARK |-> power_good && fan_run && !main_rail_en)
    else $error("parked outputs wrong");
  a_park_wake: assert property (@(posedge clk) disable iff (rst)
    state == ST_PARK && !wake_line_in && !fault && req |=> main_rail_en && state == ST_ON)
    else $error("parked supply did not wake");
  a_rok_fault: assert property (@(posedge clk) disable iff (rst)
    fault |=> redundancy_ok_n_oe)
    else $error("redundancy-ok not pulled on fault");
  a_std_block: assert property (@(posedge clk) disable iff (rst)
    standby_role_select == ROLE_STD && $past(req) |-> wake_line_oe)
    else $error("default role not holding wake line");

  c_park: cover property (@(posedge clk) disable iff (rst) $rose(state == ST_PARK));
  c_pwok: cover property (@(posedge clk) disable iff (rst) $rose(power_good));
  c_role_wr: cover property (@(posedge clk) disable iff (rst) cmd_valid && cmd_write && cmd_code == ROLE_CMD);
  c_wake: cover property (@(posedge clk) disable iff (rst) state == ST_PARK ##1 state == ST_ON);
endmodule // pso_sequencer

/* File: hw/pso_pkg.sv */
// constants and types of the output-on and standby sequencer
package pso_pkg;
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  // least main power-up delay after the on request
  localparam int unsigned ON_DLY_MS = 5;
  // least output-good delay after the outputs settle
  localparam int unsigned PWOK_DLY_MS = 100;
  // standby turn-off delays per position
  localparam int unsigned PARK_DLY1_MS = 800;
  localparam int unsigned PARK_DLY2_MS = 600;
  localparam int unsigned PARK_DLY3_MS = 400;
  // indicator blink half period
  localparam int unsigned BLINK_MS = 250;
  localparam int unsigned TMR_W = 32;

  // power management bus command code of the role register
  localparam logic [7:0] ROLE_CMD = 8'hD0;
  localparam logic [7:0] ROLE_RESET = 8'h00;
  localparam logic [7:0] ROLE_STD = 8'h00;
  localparam logic [7:0] ROLE_ACTIVE = 8'h01;
  localparam logic [7:0] ROLE_STBY1 = 8'h02;
  localparam logic [7:0] ROLE_STBY2 = 8'h03;
  localparam logic [7:0] ROLE_STBY3 = 8'h04;
  localparam logic [7:0] ROLE_STBY4 = 8'h05;

  // load-share levels below which a standby position may park
  localparam logic [7:0] WAKE_THR1 = 8'h40;
  localparam logic [7:0] WAKE_THR2 = 8'h60;
  localparam logic [7:0] WAKE_THR3 = 8'h80;

  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_RAMP = 2'b01,
    ST_ON = 2'b10,
    ST_PARK = 2'b11
  } pso_state_type;
endpackage

/* File: hw/pso_timer.sv */
// restartable millisecond delay counter
`timescale 1ns/1ns
module pso_timer (
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  input wire logic [pso_pkg::TMR_W-1:0] limit,
  output logic done
);
  import pso_pkg::*;
  logic [TMR_W-1:0] cnt;
  logic [TMR_W-1:0] next_cnt;
  logic next_done;

  always_comb begin
    next_cnt = cnt;
    next_done = done;
    if (!run) begin
      // dropping the condition restarts the count
      next_cnt = '0;
      next_done = 1'b0;
    end else if (cnt >= limit - 1) begin
      next_done = 1'b1;
    end else begin
      next_cnt = cnt + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt <= '0;
      done <= 1'b0;
    end else begin
      cnt <= next_cnt;
      done <= next_done;
    end
  end
endmodule // pso_timer

/* File: sim/pso_partner.sv */
// wired standby-wake and redundancy-ok lines of the parallel supplies
`timescale 1ns/1ns
module pso_partner (
  input wire logic wake_line_oe,
  input wire logic redundancy_ok_n_oe,
  input wire logic pull_wake,
  input wire logic pull_ok,
  output logic wake_line_in,
  output logic redundancy_ok_n_in
);
  // open drain with system pull-up, so a released wire reads high
  assign wake_line_in = !(wake_line_oe || pull_wake);
  assign redundancy_ok_n_in = !(redundancy_ok_n_oe || pull_ok);
endmodule // pso_partner

/* File: sim/psu_on_pwok_standby_sequencer_tb.sv */
// self-checking bench of the output-on and standby sequencer
`timescale 1ns/1ns
module psu_on_pwok_standby_sequencer_tb;
  import pso_pkg::*;
  localparam int unsigned ON = 5;
  localparam int unsigned PW = 10;
  logic clk = 0, rst = 1, req_n = 1, in_reg = 0, climit = 0, pwr_lost = 0, fault = 0, warning = 0;
  logic red_wake_n = 1, pull_wake = 0, pull_ok = 0, cmd_valid = 0, cmd_write = 0;
  logic [7:0] load = 8'hFF, cmd_code = 8'h00, cmd_wdata = 8'h00, rdata, role;
  logic wake_in, wake_oe, ok_in, ok_oe, ack, nak, rail, pg, fan, sfault, green, amber;
  int miscompares = 0, compares = 0;

  pso_sequencer #(.ON_DLY_CYC(ON), .PWOK_DLY_CYC(PW), .PARK1_CYC(12), .PARK2_CYC(9), .PARK3_CYC(6),
    .BLINK_CYC(4)) u_pso_sequencer (.clk(clk), .rst(rst), .main_on_request_pin_n(req_n),
    .outputs_in_reg(in_reg), .current_limit(climit), .input_power_lost(pwr_lost), .fault(fault),
    .warning(warning), .redundancy_wake_n(red_wake_n), .wake_line_in(wake_in), .wake_line_oe(wake_oe),
    .redundancy_ok_n_in(ok_in), .redundancy_ok_n_oe(ok_oe), .load_share_level(load),
    .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
    .cmd_ack(ack), .cmd_nak(nak), .cmd_rdata(rdata), .main_rail_en(rail), .power_good(pg),
    .fan_run(fan), .status_fault(sfault), .led_green(green), .led_amber(amber),
    .standby_role_select(role));
  pso_partner u_pso_partner (.wake_line_oe(wake_oe), .redundancy_ok_n_oe(ok_oe), .pull_wake(pull_wake),
    .pull_ok(pull_ok), .wake_line_in(wake_in), .redundancy_ok_n_in(ok_in));

  initial begin
    forever #25 clk = !clk;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // bounded wait on rail (sel 0) or output-good (sel 1)
  task automatic wait_on(input logic sel, input logic v, input int lim);
    for (int i = 0; i < lim && (sel ? pg : rail) !== v; i++) tick(1);
  endtask
  task automatic cmd(input logic wr, input logic [7:0] code, input logic [7:0] data, input logic [7:0] exp_rd);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_write <= wr;
    cmd_code <= code;
    cmd_wdata <= data;
    @(posedge clk);
    cmd_valid <= 1'b0;
    #1;
    chk(ack, code == ROLE_CMD);
    chk(nak, code != ROLE_CMD);
    if (!wr) chk(rdata, exp_rd);
  endtask

  task automatic t_cmds;
    chk(role, ROLE_RESET);
    for (int v = 0; v < 6; v++) begin
      cmd(1'b1, ROLE_CMD, v[7:0], 8'h00);
      cmd(1'b0, ROLE_CMD, 8'h00, v[7:0]);
    end
    cmd(1'b0, 8'h99, 8'h00, 8'h00);
    cmd(1'b1, ROLE_CMD, ROLE_STD, 8'h00);
  endtask

  task automatic t_power;
    @(posedge clk);
    req_n <= 1'b0;
    in_reg <= 1'b1;
    climit <= 1'b1;
    tick(ON);
    chk(rail, 1'b0);
    wait_on(1'b0, 1'b1, 10);
    chk(rail, 1'b1);
    chk(wake_oe, 1'b1);
    tick(PW + 3);
    chk(pg, 1'b0);
    climit <= 1'b0;
    tick(PW - 2);
    chk(pg, 1'b0);
    wait_on(1'b1, 1'b1, 6);
    chk(pg, 1'b1);
    in_reg <= 1'b0;
    tick(2);
    chk(pg, 1'b0);
    in_reg <= 1'b1;
    wait_on(1'b1, 1'b1, PW + 6);
    chk(pg, 1'b1);
    req_n <= 1'b1;
    tick(2);
    chk(rail, 1'b0);
    chk(pg, 1'b0);
  endtask

  // over 12 cycles a blinking led shows both levels
  task automatic blink_chk(input logic warn);
    logic g_on, g_off, a_on, a_off;
    g_on = 1'b0;
    g_off = 1'b0;
    a_on = 1'b0;
    a_off = 1'b0;
    repeat (12) begin
      tick(1);
      g_on = g_on | green;
      g_off = g_off | !green;
      a_on = a_on | amber;
      a_off = a_off | !amber;
    end
    chk(g_on, !warn);
    chk(g_off, 1'b1);
    chk(a_on, warn);
    chk(a_off, 1'b1);
    chk(rail, 1'b0);
  endtask

  // park in a standby position, then wake by the wake line or by redundancy-ok
  task automatic t_park(input logic [7:0] r, input logic [7:0] lvl, input int dly, input logic by_ok);
    cmd(1'b1, ROLE_CMD, r, 8'h00);
    @(posedge clk);
    load <= lvl;
    req_n <= 1'b0;
    wait_on(1'b1, 1'b1, 40);
    tick(dly - 4);
    chk(rail, 1'b1);
    wait_on(1'b0, 1'b0, 10);
    chk(rail, 1'b0);
    chk(pg, 1'b1);
    chk(fan, 1'b1);
    chk(sfault, 1'b0);
    blink_chk(1'b0);
    warning <= 1'b1;
    blink_chk(1'b1);
    warning <= 1'b0;
    if (by_ok) pull_ok <= 1'b1;
    else pull_wake <= 1'b1;
    tick(2);
    chk(rail, 1'b1);
    pull_ok <= 1'b0;
    pull_wake <= 1'b0;
    req_n <= 1'b1;
    tick(3);
  endtask

  // load above threshold or wake asserted must keep the supply on; a fault clears the role
  task automatic t_hold_fault;
    cmd(1'b1, ROLE_CMD, ROLE_STBY1, 8'h00);
    @(posedge clk);
    load <= 8'h50;
    req_n <= 1'b0;
    tick(40);
    chk(rail, 1'b1);
    load <= 8'h20;
    red_wake_n <= 1'b0;
    tick(20);
    chk(rail, 1'b1);
    fault <= 1'b1;
    tick(2);
    chk(role, ROLE_STD);
    chk(rail, 1'b0);
    chk(sfault, 1'b1);
    chk(ok_oe, 1'b1);
    fault <= 1'b0;
    req_n <= 1'b1;
    red_wake_n <= 1'b1;
    tick(2);
  endtask

  task automatic stop_test;
    $display("comparisons %0d, mismatches %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    tick(8);
    rst <= 1'b0;
    tick(1);
    t_cmds();
    t_power();
    t_park(ROLE_STBY1, 8'h20, 12, 1'b0);
    t_park(ROLE_STBY2, 8'h50, 9, 1'b1);
    t_park(ROLE_STBY3, 8'h70, 6, 1'b0);
    t_park(ROLE_STBY4, 8'h70, 6, 1'b1);
    t_hold_fault();
    stop_test();
  end

  // watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    stop_test();
  end
endmodule // psu_on_pwok_standby_sequencer_tb
